// ---- src/lcp_pkg.sv ----
package lcp_pkg;

  // Register byte addresses on the APB.
  localparam logic [11:0] ADDR_CONTROL   = 12'h000;
  localparam logic [11:0] ADDR_PHASE     = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT  = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK  = 12'h00c;
  localparam logic [11:0] ADDR_SYS_CTRL  = 12'h010;
  localparam logic [11:0] ADDR_PIX_BASE  = 12'h040;
  localparam int          PIX_REGS       = 16;

  // Field positions of display_control.
  localparam int CTL_EN    = 7;
  localparam int CTL_SLP   = 6;
  localparam int CTL_WRITE_FAILED_FLAG  = 5;
  localparam int CTL_CS_LO = 2;
  localparam int CTL_MX_LO = 0;

  // Field positions of display_phase.
  localparam int PH_WFT    = 7;
  localparam int PH_BIAS   = 6;
  localparam int PH_ACT    = 5;
  localparam int PH_WA     = 4;
  localparam int PH_PS_LO  = 0;

  localparam logic [7:0] CONTROL_RST = 8'h03;
  localparam logic [7:0] PHASE_RST   = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'hcf;
  localparam logic [7:0] PHASE_WMASK   = 8'hcf;

  // Interrupt status bits.
  localparam int IRQ_WRITE_FAILED_FLAG  = 0;
  localparam int IRQ_FRAME = 1;
  localparam int IRQ_W     = 2;

  localparam logic [1:0] CS_SYS  = 2'h0;
  localparam logic [1:0] CS_TMR  = 2'h1;
  localparam logic [8:0] SYS_DIV = 9'h100;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] phase;
  } lcp_cfg_t;

  typedef struct packed {
    logic [1:0] com_idx;
    logic       phase;
    logic       win;
    logic       active;
    logic       frame_end;
  } lcp_tim_t;

endpackage : lcp_pkg

// ---- src/lcp_timing.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcp_timing (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [3:0]       prescale,
  input  wire logic [1:0]       mux,
  input  wire logic             type_b,
  output lcp_pkg::lcp_tim_t     tim
);
  import lcp_pkg::*;

  typedef struct packed {
    logic [3:0] pre;
    logic [1:0] com;
    logic       half;
    logic       fphase;
    lcp_tim_t   o;
  } lcp_tst_t;

  lcp_tst_t s_r;
  lcp_tst_t s_nxt;

  always_comb begin
    s_nxt             = s_r;
    s_nxt.o.frame_end = 1'b0;
    s_nxt.o.active    = run;
    if (!run) begin
      s_nxt.pre  = '0;
      s_nxt.com  = '0;
      s_nxt.half = 1'b0;
    end else if (s_r.com > mux) begin
      // A smaller commons count written mid-frame would leave the slot
      // counter past the last common; restart the frame instead.
      s_nxt.pre  = '0;
      s_nxt.com  = '0;
      s_nxt.half = 1'b0;
    end else if (tick) begin
      // Prescaler divides the selected clock by prescale+1.
      if (s_r.pre == prescale) begin
        s_nxt.pre  = '0;
        s_nxt.half = ~s_r.half;
        if (s_r.half) begin
          if (s_r.com == mux) begin
            s_nxt.com         = '0;
            s_nxt.fphase      = ~s_r.fphase;
            s_nxt.o.frame_end = 1'b1;
          end else begin
            s_nxt.com = s_r.com + 2'h1;
          end
        end
      end else begin
        s_nxt.pre = s_r.pre + 4'h1;
      end
    end
    s_nxt.o.com_idx = s_nxt.com;
    // Type-B flips per frame, Type-A within each common slot.
    s_nxt.o.phase = type_b ? s_nxt.fphase : s_nxt.half;
    // Pixel writes open only in the last common slot's second half, so a
    // frame is never shown half old, half new; idle also allows.
    s_nxt.o.win = !run || (s_nxt.com == mux && s_nxt.half);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.o.win <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tim = s_r.o;
endmodule : lcp_timing
`default_nettype wire

// ---- src/lcp_driver.sv ----
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Driver runs only while enable bit set
// - Sleep bit set halts driver in sleep
// - Refused pixel write sets sticky failed flag
// - Clock source field picks driver clock
// - Static/four commons: phase write clears bias bit
// - Two/three commons: bias bit picks half/third
// - Commons field sets multiplex, resets four
// - Waveform bit picks Type-A or Type-B
// - Active status shows driver operating
// - Write-allow status shows writes accepted
// - Pixel bit one dark, zero clear
module lcp_driver #(
  parameter int SEGS = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             sleep_req,
  input  wire logic             timer_osc,
  input  wire logic             lf_osc,
  output logic [3:0]            com_drive,
  output logic [3:0]            com_en,
  output logic [SEGS-1:0]       seg_dark,
  output logic                  wave_phase,
  output logic [1:0]            bias_sel,
  output logic                  irq
);
  import lcp_pkg::*;

  typedef struct packed {
    lcp_cfg_t   cfg;
    logic [2:0] ist;
    logic [2:0] imask;
    logic       sleep_gate;
    logic [7:0] div;
    logic [2:0] tmr_s;
    logic [2:0] lf_s;
    logic [31:0] rdata;
    logic [3:0]  com;
    logic [3:0]  com_en;
    logic [SEGS-1:0] seg;
    logic        ph;
    logic [1:0]  bias;
    logic [PIX_REGS*SEGS-1:0] pix;
  } lcp_st_t;

  lcp_st_t r;
  lcp_st_t n;
  lcp_tim_t tim;
  logic tick;
  logic run;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction : hit

  wire logic acc   = psel && penable;
  wire logic wr    = acc && pwrite;
  wire logic pix_a = paddr >= ADDR_PIX_BASE &&
                     paddr < ADDR_PIX_BASE + 12'(PIX_REGS * 4);
  wire logic [3:0] pix_i = 4'(paddr[5:2]);
  wire logic [1:0] cs = r.cfg.control[CTL_CS_LO+:2];
  wire logic [1:0] mux = r.cfg.control[CTL_MX_LO+:2];

  // Driver runs when enabled and not parked by sleep.
  assign run = r.cfg.control[CTL_EN] && !r.sleep_gate;

  // System source ticks once per SYS_DIV cycles; timer and LF pins pass two flops, then their rising edge ticks.
  always_comb begin
    if (cs == CS_SYS) begin
      tick = r.div == 8'(SYS_DIV - 9'h1);
    end else if (cs == CS_TMR) begin
      tick = r.tmr_s[1] && !r.tmr_s[2];
    end else begin
      tick = r.lf_s[1] && !r.lf_s[2];
    end
  end

  lcp_timing u_tim (
    .clk      (clk),
    .resetn   (resetn),
    .run      (run),
    .tick     (tick),
    .prescale (r.cfg.phase[PH_PS_LO+:4]),
    .mux      (mux),
    .type_b   (r.cfg.phase[PH_WFT]),
    .tim      (tim)
  );

  always_comb begin
    logic write_failed_flag_set;
    logic [7:0] wv;
    write_failed_flag_set = 1'b0;
    wv       = pwdata[7:0];
    n        = r;
    n.div    = r.div + 8'h1;
    n.tmr_s  = {r.tmr_s[1:0], timer_osc};
    n.lf_s   = {r.lf_s[1:0], lf_osc};
    n.sleep_gate = sleep_req && r.cfg.control[CTL_SLP];
    if (wr) begin
      if (hit(paddr, ADDR_CONTROL)) begin
        n.cfg.control = (r.cfg.control & ~CONTROL_WMASK) | (wv & CONTROL_WMASK);
        // Error flag is clear-only from software.
        n.cfg.control[CTL_WRITE_FAILED_FLAG] = r.cfg.control[CTL_WRITE_FAILED_FLAG] & wv[CTL_WRITE_FAILED_FLAG];
      end
      if (hit(paddr, ADDR_PHASE)) begin
        n.cfg.phase = (r.cfg.phase & ~PHASE_WMASK) | (wv & PHASE_WMASK);
        // Bias bit is forced to zero for static and four commons.
        if (mux == 2'h0 || mux == 2'h3) begin
          n.cfg.phase[PH_BIAS] = 1'b0;
        end
      end
      if (hit(paddr, ADDR_IRQ_STAT)) begin
        n.ist = r.ist & ~pwdata[IRQ_W-1+1:0];
      end
      if (hit(paddr, ADDR_IRQ_MASK)) begin
        n.imask = pwdata[IRQ_W:0];
      end
      if (pix_a) begin
        if (tim.win) begin
          n.pix[pix_i*SEGS+:SEGS] = pwdata[SEGS-1:0];
        end else begin
          write_failed_flag_set = 1'b1;
        end
      end
    end
    // Hardware set wins over a same-cycle software clear.
    if (write_failed_flag_set) begin
      n.cfg.control[CTL_WRITE_FAILED_FLAG] = 1'b1;
      n.ist[IRQ_WRITE_FAILED_FLAG] = 1'b1;
    end
    if (tim.frame_end) begin
      n.ist[IRQ_FRAME] = 1'b1;
    end
    n.cfg.phase[PH_ACT] = tim.active;
    n.cfg.phase[PH_WA]  = tim.win;
    n.rdata = '0;
    if (acc && !pwrite) begin
      if (hit(paddr, ADDR_CONTROL)) n.rdata[7:0] = r.cfg.control;
      if (hit(paddr, ADDR_PHASE))   n.rdata[7:0] = r.cfg.phase;
      if (hit(paddr, ADDR_IRQ_STAT)) n.rdata[IRQ_W:0] = r.ist;
      if (hit(paddr, ADDR_IRQ_MASK)) n.rdata[IRQ_W:0] = r.imask;
      if (pix_a) n.rdata[SEGS-1:0] = r.pix[pix_i*SEGS+:SEGS];
    end
    // Commons beyond the multiplex ratio stay undriven.
    n.com_en = 4'h0;
    for (int i = 0; i < 4; i++) begin
      n.com_en[i] = run && (2'(i) <= mux);
    end
    n.com = '0;
    // The slot index lags a commons write by a cycle; never drive past it.
    n.com[tim.com_idx] = run && (tim.com_idx <= mux);
    // Dark pixel gets the full swing; a zero bit stays clear.
    n.seg = run ? r.pix[{2'h0, tim.com_idx}*SEGS+:SEGS] : '0;
    n.ph  = tim.phase;
    // 00 static, 01 half bias, 10 third bias.
    if (mux == 2'h0) begin
      n.bias = 2'h0;
    end else if (mux != 2'h3 && r.cfg.phase[PH_BIAS]) begin
      n.bias = 2'h1;
    end else begin
      n.bias = 2'h2;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
      r.cfg.control <= CONTROL_RST;
      r.cfg.phase   <= PHASE_RST;
    end else begin
      r <= n;
    end
  end

  wire logic mapped = hit(paddr, ADDR_CONTROL) || hit(paddr, ADDR_PHASE) ||
                      hit(paddr, ADDR_IRQ_STAT) || hit(paddr, ADDR_IRQ_MASK) || pix_a;

  // Reads need one wait state so the data comes from a flop.
  logic rd_wait_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= acc && !pwrite && !rd_wait_r;
    end
  end

  assign pready     = acc && (pwrite || rd_wait_r);
  assign pslverr    = pready && !mapped;
  assign prdata     = r.rdata;
  assign com_drive  = r.com;
  assign com_en     = r.com_en;
  assign seg_dark   = r.seg;
  assign wave_phase = r.ph;
  assign bias_sel   = r.bias;
  assign irq        = |(r.ist & r.imask);
endmodule : lcp_driver
`default_nettype wire

// ---- dv/lcp_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcp_properties (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  com_drive,
  input wire logic [3:0]  com_en,
  input wire logic [1:0]  bias_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  one_common_a: assert property ($onehot0(com_drive) && !(com_drive & ~com_en))
    else $error("common drive outside the enabled set");
  static_bias_a: assert property (com_en == 4'h1 |-> bias_sel == 2'h0)
    else $error("static panel not on static bias");
  four_bias_a: assert property (com_en == 4'hf |-> bias_sel == 2'h2)
    else $error("four commons not on third bias");
  mid_bias_a: assert property (com_en inside {4'h3, 4'h7} |-> bias_sel inside {2'h1, 2'h2})
    else $error("two or three commons on static bias");
  stop_idle_a: assert property (com_en == 4'h0 |-> com_drive == 4'h0)
    else $error("common driven while stopped");
  write_ready_a: assert property (psel && penable && pwrite |-> pready)
    else $error("write not answered at once");
  read_wait_a: assert property (psel && $rose(penable) && !pwrite |-> !pready ##1 pready)
    else $error("read not answered after one wait");
  err_zero_a: assert property (psel && penable && pready && pslverr && !pwrite |-> prdata == 0)
    else $error("unmapped read not zero");
endmodule : lcp_properties
`default_nettype wire

// ---- dv/lcp_panel.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcp_panel (
  input wire logic       clk,
  input wire logic [3:0] com_drive,
  input wire logic [7:0] seg_dark,
  output logic [3:0][7:0] seen
);
  // The glass only darkens where its common is driven, so keep the last pattern per common.
  always_ff @(posedge clk)
    for (int c = 0; c < 4; c++)
      if (com_drive[c]) seen[c] <= seg_dark;
endmodule : lcp_panel
`default_nettype wire

// ---- dv/lcd_driver_control_phase_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcd_driver_control_phase_tb;
  import lcp_pkg::*;
  logic clk, resetn, psel, penable, pwrite, sleep_req, timer_osc, lf_osc;
  logic pready, pslverr, irq, wave_phase, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] com_drive, com_en;
  logic [7:0] seg_dark;
  logic [1:0] bias_sel;
  logic [3:0][7:0] seen, pix;
  int n_fail, check_count, gap;
  lcp_driver lcp_driver_i (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sleep_req, .timer_osc, .lf_osc, .com_drive, .com_en,
    .seg_dark, .wave_phase, .bias_sel, .irq);
  lcp_panel lcp_panel_i (.clk, .com_drive, .seg_dark, .seen);
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always #500 timer_osc = ~timer_osc;
  always #16129 lf_osc = ~lf_osc;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) chk(0, 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (k == 50) end_of_test();
  endtask : bus
  task automatic wait_ph(input int b, input logic v);
    int k;
    for (k = 0; k < 1500; k++) begin
      bus(0, ADDR_PHASE, 0);
      if (rd[b] === v) break;
    end
    chk(rd[b], v);
    if (k == 1500) end_of_test();
  endtask : wait_ph
  task automatic wait_chg(input bit ph, output int k);
    logic [3:0] c0;
    c0 = ph ? {3'h0, wave_phase} : com_drive;
    for (k = 0; k < 5000 && (ph ? {3'h0, wave_phase} : com_drive) === c0; k++) @(posedge clk);
    chk(k < 5000, 1);
    if (k == 5000) end_of_test();
  endtask : wait_chg
  initial begin
    {psel, penable, pwrite, sleep_req, timer_osc, lf_osc} = 0;
    paddr = 0;
    pwdata = 0;
    resetn = 0;
    n_fail = 0;
    check_count = 0;
    void'($urandom(67200));
    repeat (12) @(posedge clk);
    resetn <= 1;
    bus(0, ADDR_CONTROL, 0);
    chk(rd, 32'h03);
    bus(0, ADDR_PHASE, 0);
    chk(rd, 32'h10);
    bus(1, ADDR_SYS_CTRL, 1);
    chk(err, 1);
    bus(0, ADDR_SYS_CTRL, 0);
    chk(err, 1);
    chk(rd, 0);
    for (int c = 0; c < 4; c++) begin
      pix[c] = 8'($urandom);
      bus(1, ADDR_PIX_BASE + 12'(4 * c), 32'(pix[c]));
      bus(0, ADDR_PIX_BASE + 12'(4 * c), 0);
      chk(rd, 32'(pix[c]));
    end
    bus(1, ADDR_IRQ_MASK, 1);
    bus(1, ADDR_PHASE, {24'h0, 1'($urandom_range(1)), 7'h01});
    bus(1, ADDR_CONTROL, 32'h87);
    wait_ph(PH_ACT, 1);
    wait_ph(PH_WA, 0);
    bus(1, ADDR_PIX_BASE, 32'(~pix[0]));
    bus(0, ADDR_CONTROL, 0);
    chk(rd, 32'ha7);
    bus(1, ADDR_IRQ_MASK, 0);
    @(posedge clk);
    chk(irq, 0);
    bus(1, ADDR_IRQ_MASK, 1);
    @(posedge clk);
    chk(irq, 1);
    bus(1, ADDR_IRQ_STAT, 1);
    bus(1, ADDR_CONTROL, 32'h87);
    chk(irq, 0);
    bus(0, ADDR_PIX_BASE, 0);
    chk(rd, 32'(pix[0]));
    wait_ph(PH_WA, 1);
    pix[0] = 8'($urandom);
    bus(1, ADDR_PIX_BASE, 32'(pix[0]));
    wait_ph(PH_WA, 0);
    wait_ph(PH_WA, 1);
    for (int c = 0; c < 4; c++) chk(seen[c], pix[c]);
    bus(0, ADDR_IRQ_STAT, 0);
    chk(rd, 32'(1 << IRQ_FRAME));
    for (int m = 0; m < 4; m++) begin
      bus(1, ADDR_CONTROL, 32'h84 | m);
      bus(1, ADDR_PHASE, 32'h40);
      bus(0, ADDR_PHASE, 0);
      chk(rd & 32'h40, (m == 1 || m == 2) ? 32'h40 : 0);
      chk(bias_sel, m == 0 ? 0 : (m == 3 ? 2 : 1));
      chk(com_en, (1 << (m + 1)) - 1);
    end
    bus(1, ADDR_PHASE, 32'h01);
    for (int s = 0; s < 3; s++) begin
      bus(1, ADDR_CONTROL, 32'h83 | (s << 2));
      wait_chg(0, gap);
      wait_chg(0, gap);
      // One common slot is two halves of prescale+1 ticks each.
      if (s == 0) chk(gap, 4 * SYS_DIV);
    end
    bus(1, ADDR_CONTROL, 32'h83);
    bus(1, ADDR_PHASE, 32'h00);
    wait_chg(1, gap);
    wait_chg(1, gap);
    chk(gap, SYS_DIV);
    bus(1, ADDR_PHASE, 32'h80);
    // The type switch itself may flip the phase once, so skip two changes.
    wait_chg(1, gap);
    wait_chg(1, gap);
    wait_chg(1, gap);
    chk(gap, 8 * SYS_DIV);
    sleep_req <= 1;
    bus(1, ADDR_CONTROL, 32'h87);
    wait_ph(PH_ACT, 1);
    bus(1, ADDR_CONTROL, 32'hc7);
    wait_ph(PH_ACT, 0);
    sleep_req <= 0;
    wait_ph(PH_ACT, 1);
    bus(1, ADDR_CONTROL, 32'h07);
    wait_ph(PH_ACT, 0);
    end_of_test();
  end
endmodule : lcd_driver_control_phase_tb
bind lcp_driver lcp_properties lcp_properties_i (.clk, .resetn, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .com_drive, .com_en, .bias_sel);
`default_nettype wire
